//--- inc/dbgts_pkg.sv
// Constants for the debug trigger and run-status block
// Function
// - Trigger config always readable; writes ignored while arm control bit is set.
// - Trigger config bits 4 and 5 always read zero.
// - Bit 7: 0 force triggers on access, 1 tag needs opcode executed.
// - Bit 6: 0 end trace circular fill, 1 trigger begins storage.
// - Event-only modes ignore bit 6 and always run as begin trace.
// - Modes 0000 to 0110: A, A or B, A then B, event B, A then event B, A and B, A not B.
// - 0111 inside range A..B, 1000 outside range, 1001-1111 never trigger.
// - Status bit 7 clears at run start, sets on comparator A match.
// - Status bit 6 clears at run start, sets on comparator B match.
// - While enabled, status bit 5 mirrors arm control bit.
// - Run ends on FIFO full in begin trace or trigger in end trace.
// - Writing 0 to arm or enable ends a run at once.
// - Valid count clears at run start, holds 0 to 8 words at run end.
// - Valid count never decrements on FIFO reads.
// - Status register is read-only; writes have no effect.
// - Writing arm sets arm and armed flag; run completion clears arm. Arm sets only if the same write leaves the module enabled.
// - Enable bit cannot be set while device is secure.
// - With breaks on: begin trace breaks on FIFO full, end trace on trigger.
package dbgts_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [11:0] DBGTS_OFS_CTRL = 12'h000;
	localparam logic [11:0] DBGTS_OFS_TRIG = 12'h004;
	localparam logic [11:0] DBGTS_OFS_STAT = 12'h008;
	localparam logic [11:0] DBGTS_OFS_CMPA = 12'h00c;
	localparam logic [11:0] DBGTS_OFS_CMPB = 12'h010;
	// ==========================================================
	// Control fields
	localparam int DBGTS_C_EN = 7;
	localparam int DBGTS_C_ARM = 6;
	localparam int DBGTS_C_BRK = 4;
	localparam int DBGTS_C_RWA = 3;
	localparam int DBGTS_C_RWAEN = 2;
	localparam int DBGTS_C_RWB = 1;
	localparam int DBGTS_C_RWBEN = 0;
	// ==========================================================
	// Trigger and status fields
	localparam int DBGTS_T_TYPE = 7;
	localparam int DBGTS_T_BEGIN = 6;
	localparam logic [7:0] DBGTS_T_WMASK = 8'hcf;
	localparam int DBGTS_S_AF = 7;
	localparam int DBGTS_S_BF = 6;
	localparam int DBGTS_S_ARMED_FLAG = 5;
	localparam logic [7:0] DBGTS_RST8 = 8'h00;
	localparam logic [3:0] DBGTS_FIFO_DEPTH = 4'h8;
	// ==========================================================
	// Trigger modes
	localparam logic [3:0] DBGTS_M_A = 4'h0;
	localparam logic [3:0] DBGTS_M_AORB = 4'h1;
	localparam logic [3:0] DBGTS_M_ATHENB = 4'h2;
	localparam logic [3:0] DBGTS_M_EVB = 4'h3;
	localparam logic [3:0] DBGTS_M_AEVB = 4'h4;
	localparam logic [3:0] DBGTS_M_AANDB = 4'h5;
	localparam logic [3:0] DBGTS_M_ANOTB = 4'h6;
	localparam logic [3:0] DBGTS_M_IN = 4'h7;
	localparam logic [3:0] DBGTS_M_OUT = 4'h8;
endpackage : dbgts_pkg

//--- hw/dbgts_cmp.sv
// Address comparator with optional direction qualifier
`timescale 1ns/1ps
`default_nettype none
module dbgts_cmp #(
	parameter int AW = 16
) (
	input wire logic [AW-1:0] addr,
	input wire logic rd,
	input wire logic [AW-1:0] value,
	input wire logic rw_en,
	input wire logic rw_val,
	output logic hit,
	output logic below,
	output logic above
);
	wire dir_ok = !rw_en || (rw_val == rd);
	assign hit = (addr == value) && dir_ok;
	assign below = addr < value;
	assign above = addr > value;
endmodule : dbgts_cmp
`default_nettype wire

//--- hw/dbgts_top.sv
// Debug trigger selection and run status with APB register access
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dbgts_top #(
	parameter int AW = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic secure,
	input wire logic bus_valid,
	input wire logic [AW-1:0] bus_addr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_data,
	input wire logic opcode_exec,
	input wire logic fifo_full,
	input wire logic [3:0] fifo_level,
	output logic fifo_store,
	output logic [AW-1:0] fifo_word,
	output logic break_req
);
	import dbgts_pkg::*;
	// Store word needs room for a data byte; read mux needs a spare bit
	if (AW < 9 || AW > 31) begin : g_aw_check
		$error("dbgts_top: AW must lie between 9 and 31");
	end
	// ==========================================================
	// Registers
	logic [7:0] ctrl_r;
	logic [7:0] trig_r;
	logic af_r;
	logic bf_r;
	logic a_seen_r;
	logic capture_r;
	logic [3:0] count_r;
	logic [AW-1:0] cmpa_r;
	logic [AW-1:0] cmpb_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic break_r;
	logic store_r;
	logic [AW-1:0] word_r;
	// ==========================================================
	// Bus decode
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire hit_ctrl = paddr == DBGTS_OFS_CTRL;
	wire hit_trig = paddr == DBGTS_OFS_TRIG;
	wire hit_stat = paddr == DBGTS_OFS_STAT;
	wire hit_cmpa = paddr == DBGTS_OFS_CMPA;
	wire hit_cmpb = paddr == DBGTS_OFS_CMPB;
	wire mapped = hit_ctrl || hit_trig || hit_stat || hit_cmpa || hit_cmpb;
	wire wr_ctrl = wr && hit_ctrl;
	wire wr_trig = wr && hit_trig && !ctrl_r[DBGTS_C_ARM];
	wire armed = ctrl_r[DBGTS_C_ARM];
	wire enabled = ctrl_r[DBGTS_C_EN];
	// ==========================================================
	// Comparators
	logic a_hit;
	logic b_hit;
	logic a_below;
	logic b_above;
	dbgts_cmp #(
		.AW(AW)
	) u_cmpa (
		.addr(bus_addr),
		.rd(bus_rd),
		.value(cmpa_r),
		.rw_en(ctrl_r[DBGTS_C_RWAEN]),
		.rw_val(ctrl_r[DBGTS_C_RWA]),
		.hit(a_hit),
		.below(a_below),
		.above()
	);
	dbgts_cmp #(
		.AW(AW)
	) u_cmpb (
		.addr(bus_addr),
		.rd(bus_rd),
		.value(cmpb_r),
		.rw_en(ctrl_r[DBGTS_C_RWBEN]),
		.rw_val(ctrl_r[DBGTS_C_RWB]),
		.hit(b_hit),
		.below(),
		.above(b_above)
	);
	// Tag type waits for the opcode to execute; force fires on access
	wire qual = !trig_r[DBGTS_T_TYPE] || opcode_exec;
	wire run = armed && enabled && bus_valid;
	wire ma = run && a_hit && qual;
	wire mb = run && b_hit && qual;
	wire [3:0] mode = trig_r[3:0];
	wire event_only = (mode == DBGTS_M_EVB) || (mode == DBGTS_M_AEVB);
	wire begin_trace = trig_r[DBGTS_T_BEGIN] || event_only;
	wire in_range = !a_below && !b_above;
	// ==========================================================
	// Trigger decode
	logic trig_hit;
	always_comb begin
		case (mode)
			DBGTS_M_A: trig_hit = ma;
			DBGTS_M_AORB: trig_hit = ma || mb;
			DBGTS_M_ATHENB: trig_hit = a_seen_r && mb;
			DBGTS_M_EVB: trig_hit = mb;
			DBGTS_M_AEVB: trig_hit = a_seen_r && mb;
			DBGTS_M_AANDB: trig_hit = ma && mb;
			DBGTS_M_ANOTB: trig_hit = ma && !mb;
			DBGTS_M_IN: trig_hit = run && qual && in_range;
			DBGTS_M_OUT: trig_hit = run && qual && !in_range;
			default: trig_hit = 1'b0;
		endcase
	end
	// Run completion
	wire done = begin_trace ? (capture_r && fifo_full) : trig_hit;
	// A run starts only if the same write leaves the module enabled
	wire start = wr_ctrl && pwdata[DBGTS_C_ARM] && pwdata[DBGTS_C_EN] && !secure;
	// ==========================================================
	// Control register
	logic [7:0] ctrl_nxt;
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = pwdata[7:0];
			ctrl_nxt[DBGTS_C_EN] = pwdata[DBGTS_C_EN] && !secure;
		end
		if (!ctrl_nxt[DBGTS_C_EN]) ctrl_nxt[DBGTS_C_ARM] = 1'b0;
		if (done && !start) ctrl_nxt[DBGTS_C_ARM] = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= DBGTS_RST8;
			trig_r <= DBGTS_RST8;
			cmpa_r <= '0;
			cmpb_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			if (wr_trig) trig_r <= pwdata[7:0] & DBGTS_T_WMASK;
			if (wr && hit_cmpa) cmpa_r <= pwdata[AW-1:0];
			if (wr && hit_cmpb) cmpb_r <= pwdata[AW-1:0];
		end
	end
	// ==========================================================
	// Run status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			af_r <= 1'b0;
			bf_r <= 1'b0;
			a_seen_r <= 1'b0;
			capture_r <= 1'b0;
			count_r <= 4'h0;
		end else if (start) begin
			af_r <= 1'b0;
			bf_r <= 1'b0;
			a_seen_r <= 1'b0;
			capture_r <= 1'b0;
			count_r <= 4'h0;
		end else begin
			if (ma) af_r <= 1'b1;
			if (mb) bf_r <= 1'b1;
			if (ma) a_seen_r <= 1'b1;
			if (armed && begin_trace && trig_hit) capture_r <= 1'b1;
			// Latched once at run end, so later FIFO reads never lower it
			if (armed && !ctrl_nxt[DBGTS_C_ARM]) begin
				count_r <= (fifo_level > DBGTS_FIFO_DEPTH) ? DBGTS_FIFO_DEPTH : fifo_level;
			end
		end
	end
	// ==========================================================
	// FIFO store and break request
	wire store_now = run && (begin_trace ? (capture_r || trig_hit) : 1'b1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_r <= 1'b0;
			word_r <= '0;
			break_r <= 1'b0;
		end else begin
			// End trace keeps overwriting a full FIFO circularly
			store_r <= store_now && (!begin_trace || !fifo_full);
			word_r <= event_only ? {{(AW-8){1'b0}}, bus_data} : bus_addr;
			break_r <= ctrl_r[DBGTS_C_BRK] && armed && done;
		end
	end
	// ==========================================================
	// Read data and answer
	wire [7:0] stat_v = {af_r, bf_r, armed && enabled, 1'b0, count_r};
	wire [31:0] rd_v = hit_ctrl ? {24'h000000, ctrl_r} :
		hit_trig ? {24'h000000, trig_r & DBGTS_T_WMASK} :
		hit_stat ? {24'h000000, stat_v} :
		hit_cmpa ? {{(32-AW){1'b0}}, cmpa_r} :
		hit_cmpb ? {{(32-AW){1'b0}}, cmpb_r} : 32'h00000000;
	// Status has no write path at all; writes to it are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= 1'b1;
			pslverr_r <= 1'b0;
			if (psel && !penable && !pwrite) prdata_r <= rd_v;
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign fifo_store = store_r;
	assign fifo_word = word_r;
	assign break_req = break_r;
	// ==========================================================
	// Checks
	arm_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && !pwdata[DBGTS_C_ARM]) |=> !ctrl_r[DBGTS_C_ARM]) else $error("arm not cleared");
	trig_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && hit_trig && armed) |=> $stable(trig_r)) else $error("trigger written while armed");
	trig_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig_r[5:4] == 2'b00) else $error("fixed bits set");
	secure_en_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && secure && !enabled) |=> !ctrl_r[DBGTS_C_EN]) else $error("enabled while secure");
	start_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> (!af_r && !bf_r && count_r == 4'h0)) else $error("run start not cleared");
	bflag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mb && !start) |=> bf_r) else $error("b flag missed");
	done_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done && !start) |=> !ctrl_r[DBGTS_C_ARM]) else $error("run not finished");
	count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!armed && !start) |=> $stable(count_r)) else $error("count changed");
	break_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_r[DBGTS_C_BRK] && armed && done) |=> break_req) else $error("break missing");
	nomatch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode > DBGTS_M_OUT) |-> !trig_hit) else $error("spurious trigger");

	sequence a_first_s;
		(mode == DBGTS_M_ATHENB) && ma && !start;
	endsequence

	sequence b_next_s;
		(mode == DBGTS_M_ATHENB) && mb && !start;
	endsequence

	a_then_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		a_first_s ##1 b_next_s |-> trig_hit) else $error("a then b missed");

	b_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_ATHENB) && !a_seen_r) |-> !trig_hit) else $error("b before a triggered");

	not_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_ANOTB) && mb) |-> !trig_hit) else $error("a and not b fired with b");

	ev_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_EVB) && mb) |-> trig_hit) else $error("event b missed");

	a_and_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_AANDB) && !mb) |-> !trig_hit) else $error("a and b fired without b");

	range_in_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_IN) && run && qual && !a_below && !b_above) |-> trig_hit)
		else $error("inside range missed");

	range_not_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_IN) && (a_below || b_above)) |-> !trig_hit) else $error("outside fired inside mode");

	range_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == DBGTS_M_OUT) && run && qual && (a_below || b_above)) |-> trig_hit)
		else $error("outside range missed");

	force_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !trig_r[DBGTS_T_TYPE] && a_hit && !start) |=> af_r) else $error("force match lost");

	tag_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(trig_r[DBGTS_T_TYPE] && !opcode_exec && !start && !af_r) |=> !af_r) else $error("tag without execute");

	aflag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ma && !start) |=> af_r) else $error("a flag missed");

	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!run && !start) |=> $stable({af_r, bf_r})) else $error("flags moved while idle");

	begin_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && begin_trace && !capture_r && !trig_hit) |=> !fifo_store) else $error("stored before trigger");

	end_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !begin_trace) |=> fifo_store) else $error("end trace store missed");

	word_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!event_only) |=> (fifo_word == $past(bus_addr))) else $error("store word not address");

	ev_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && event_only && !fifo_full && !wr_ctrl) |=> armed) else $error("event run ended early");

	capture_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> (!a_seen_r && !capture_r)) else $error("capture state kept");

	store_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!run |=> !fifo_store) else $error("store while idle");

	arm_status_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[DBGTS_C_ARM] |-> stat_v[DBGTS_S_ARMED_FLAG]) else $error("armed flag not shown");

	start_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> (ctrl_r[DBGTS_C_ARM] && ctrl_r[DBGTS_C_EN])) else $error("run did not start");

	en_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && !pwdata[DBGTS_C_EN]) |=> !ctrl_r[DBGTS_C_ARM]) else $error("disable kept run");

	count_max_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_r <= DBGTS_FIFO_DEPTH) else $error("count above depth");

	trig_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_trig |=> (trig_r == ($past(pwdata[7:0]) & DBGTS_T_WMASK))) else $error("trigger write lost");

	stat_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && hit_stat && !armed) |=> $stable({ctrl_r, af_r, bf_r, count_r})) else $error("status written");

	secure_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(secure && !enabled) |=> !ctrl_r[DBGTS_C_EN]) else $error("enable rose while secure");

	brk_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_r[DBGTS_C_BRK] |=> !break_req) else $error("break without enable");

	dir_a_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_r[DBGTS_C_RWAEN] && (ctrl_r[DBGTS_C_RWA] != bus_rd)) |-> !ma) else $error("a wrong direction");

	dir_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_r[DBGTS_C_RWBEN] && (ctrl_r[DBGTS_C_RWB] != bus_rd)) |-> !mb) else $error("b wrong direction");

endmodule : dbgts_top
`default_nettype wire

//--- bench/dbgts_fifo_model.sv
// Occupancy model of the external trace FIFO
`timescale 1ns/1ps
`default_nettype none
module dbgts_fifo_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic store,
	output logic [3:0] level,
	output logic full
);
	// ==========================================================
	// Occupancy, saturating at eight; the host counts reads itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 4'h0;
		end else if (clr) begin
			level <= 4'h0;
		end else if (store && level != 4'h8) begin
			level <= level + 4'h1;
		end
	end
	assign full = (level == 4'h8);
endmodule : dbgts_fifo_model
`default_nettype wire

//--- bench/dbgts_bench.sv
// Self-checking bench for the debug trigger and run-status block
`timescale 1ns/1ps
`default_nettype none
module dbgts_bench;
	import dbgts_pkg::*;
	// ==========================================================
	// Signals
	logic pclk, presetn, psel, penable, pwrite, secure, bus_valid, bus_rd, opcode_exec, clr;
	logic pready, pslverr, fifo_full, fifo_store, break_req;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [15:0] bus_addr, fifo_word, first_word;
	logic [7:0] bus_data;
	logic [3:0] fifo_level;
	int n_fail, total_checks, n_brk;
	dbgts_top #(.AW(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .secure, .bus_valid, .bus_addr, .bus_rd, .bus_data, .opcode_exec, .fifo_full, .fifo_level,
		.fifo_store, .fifo_word, .break_req);
	dbgts_fifo_model fifo (.pclk, .presetn, .clr, .store(fifo_store), .level(fifo_level), .full(fifo_full));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Sampled on the falling edge so registered outputs have settled
	always @(negedge pclk) begin
		if (break_req === 1'b1) n_brk++;
		if (fifo_store === 1'b1 && fifo_level == 4'h0 && clr === 1'b0) first_word = fifo_word;
	end
	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim
	// Idle cycle at the end keeps back-to-back calls from driving psel twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_fail++;
			end_sim();
		end
		rd = prdata;
		chk({31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic cyc(input logic [15:0] a);
		bus_valid <= 1'b1;
		bus_addr <= a;
		@(posedge pclk);
		bus_valid <= 1'b0;
		clr <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : cyc
	// Expected {match A, match B, still armed} for one probe in an end trace
	function automatic logic [2:0] model(input int m, input int a, input logic qa, input logic q);
		logic ha, hb, t;
		ha = (a == 'h1000) && qa;
		hb = (a == 'h2055);
		case (m)
			0, 6: t = ha;
			1: t = ha || hb;
			7: t = a >= 'h1000 && a <= 'h2055;
			8: t = a < 'h1000 || a > 'h2055;
			default: t = 1'b0;
		endcase
		return {ha && q, hb && q, !(t && q)};
	endfunction : model
	// ==========================================================
	// Main sequence
	initial begin
		int m, p, x;
		logic t;
		logic [2:0] ex;
		logic [15:0] pa [4];
		pa = '{16'h1800, 16'h0800, 16'h1000, 16'h2055};
		seed = 32'hf7235c89;
		{presetn, psel, penable, pwrite, secure, bus_valid, bus_rd, opcode_exec, clr} = '0;
		paddr = '0;
		pwdata = '0;
		bus_addr = '0;
		bus_data = 8'h00;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd, 32'h0);
		apb(1'b1, DBGTS_OFS_TRIG, 32'hff);
		apb(1'b0, DBGTS_OFS_TRIG, 0);
		chk(rd, 32'hcf);
		apb(1'b1, DBGTS_OFS_CMPA, 32'h1000);
		apb(1'b1, DBGTS_OFS_CMPB, 32'h2055);
		secure <= 1'b1;
		apb(1'b1, DBGTS_OFS_CTRL, 32'h80);
		apb(1'b0, DBGTS_OFS_CTRL, 0);
		chk(rd & 32'h80, 32'h0);
		secure <= 1'b0;
		apb(1'b1, DBGTS_OFS_CTRL, 32'hc0);
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd, 32'h20);
		apb(1'b1, DBGTS_OFS_TRIG, 32'h05);
		apb(1'b0, DBGTS_OFS_TRIG, 0);
		chk(rd, 32'hcf);
		apb(1'b1, DBGTS_OFS_STAT, 32'hff);
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd, 32'h20);
		apb(1'b0, 12'h100, 0);
		chk(rd, 32'h0);
		apb(1'b1, DBGTS_OFS_CTRL, 32'h80);
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd & 32'h20, 32'h0);
		for (m = 0; m < 16; m++) begin
			for (p = 0; p < 4; p++) begin
				x = xs();
				t = (m < 2) && x[0];
				opcode_exec <= x[4];
				bus_rd <= x[5];
				apb(1'b1, DBGTS_OFS_TRIG, {24'h0, t, x[6], 2'b00, m[3:0]});
				apb(1'b1, DBGTS_OFS_CTRL, {24'h0, 4'hc, (m < 2) ? x[3:2] : 2'b00, 2'b00});
				cyc(pa[p]);
				apb(1'b0, DBGTS_OFS_STAT, 0);
				ex = model(m, pa[p], m > 1 || !x[2] || x[5] == x[3], !t || x[4]);
				ex[0] = ex[0] || (x[6] == 1'b1);
				chk(rd & ((m < 2 || m == 7 || m == 8) ? 32'he0 : 32'h20),
					{24'h0, ex, 5'h0} & ((m < 2 || m == 7 || m == 8) ? 32'he0 : 32'h20));
				apb(1'b1, DBGTS_OFS_CTRL, 32'h80);
				clr <= 1'b1;
			end
		end
		apb(1'b1, DBGTS_OFS_TRIG, 32'h40);
		apb(1'b1, DBGTS_OFS_CTRL, 32'hd0);
		clr <= 1'b0;
		cyc(16'h1000);
		bus_valid <= 1'b1;
		bus_addr <= 16'h1800;
		repeat (30) @(posedge pclk);
		bus_valid <= 1'b0;
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd, 32'h88);
		chk(n_brk, 1);
		chk(first_word, 32'h1000);
		clr <= 1'b1;
		@(posedge pclk);
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd, 32'h88);
		apb(1'b1, DBGTS_OFS_CTRL, 32'hc0);
		apb(1'b0, DBGTS_OFS_STAT, 0);
		chk(rd, 32'h20);
		end_sim();
	end
endmodule : dbgts_bench
`default_nettype wire
